/* src/utc_upper_timer.sv */
// upper 16-bit timer of a timer pair: control register, prescaler, count and period
// assumes an avalon-mm master on the same clock; pair inputs come from the lower timer's
// logic on the same clock, ext_clock_pin is asynchronous and is synchronised here
//
// Added by the designer: the register addresses and the Avalon-MM interface to the registers.
`timescale 1ns/1ps

// Notes on behaviour
// R1: the run bit starts the 16-bit upper count and clearing it freezes the current value.
// R2: with idle halt set the timer stops while the cpu idles, and in pair mode it halts the pair too.
// R3: gated accumulation counts only while the gate is high with the internal clock selected.
// R4: the prescale field divides the input clock by 256, 64, 8 or 1 for codes 11, 10, 01, 00.
// R5: in pair mode the upper run, gate, prescale and clock source bits have no effect.
// R6: the clock source bit picks rising edges of the external pin when set, else the clock.
// R7: in pair mode the upper count holds the high word and the lower count the low word.
// R8: in pair mode the period is the upper period word above the lower period word.
// R9: the pair's interrupt is raised as the upper timer's interrupt.
module utc_upper_timer
    import utc_pkg::*;
(
    input  wire logic                      clock,              // 200 MHz system clock
    input  wire logic                      reset_n,            // async reset, active low
    input  wire logic [utc_pkg::ADDR_W-1:0] avs_address,       // byte address
    input  wire logic                      avs_read,           // read request
    input  wire logic                      avs_write,          // write request
    input  wire logic [utc_pkg::DATA_W-1:0] avs_writedata,     // write data
    output logic      [utc_pkg::DATA_W-1:0] avs_readdata,      // read data
    output logic                           avs_waitrequest,    // high while stalling
    input  wire logic                      cpu_idle,           // cpu in idle mode
    input  wire logic                      ext_clock_pin,      // external clock or gate pin
    input  wire logic                      pair_wide_select,   // lower timer joins the pair
    input  wire logic                      pair_run,           // lower timer's run bit
    input  wire logic                      pair_tick,          // lower timer prescaled tick
    input  wire logic [utc_pkg::WORD_W-1:0] count_low_word,    // lower count word
    input  wire logic [utc_pkg::WORD_W-1:0] period_low_word,   // lower period word
    output logic                           pair_wrap,          // pulse: lower word to zero
    output logic                           timer_irq,          // pulse: upper timer event
    output logic      [utc_pkg::WORD_W-1:0] count_high_word    // upper count word
);
    import utc_pkg::*;

    logic [15:0]       control_ff, nxt_control;
    logic [15:0]       count_ff, nxt_count;
    logic [15:0]       period_ff, nxt_period;
    logic [7:0]        pre_cnt_ff, nxt_pre_cnt;
    logic [31:0]       rdata_ff, nxt_rdata;
    logic              wait_ff, nxt_wait;
    logic              wrap_ff, nxt_wrap;
    logic              irq_ff, nxt_irq;
    logic              ext_s1_ff, ext_s2_ff, ext_s3_ff;
    logic              timer_run, idle_halt, gate_accumulate, clock_source_sel;
    logic [1:0]        prescale_select;
    logic              access_done, wr_control, wr_count, wr_period;
    logic              halted, single_run, raw_tick, pre_tick, gate_fall;
    logic              pair_step, pair_match, period_match;
    logic [7:0]        pre_last;

    assign timer_run        = control_ff[BIT_RUN];
    assign idle_halt        = control_ff[BIT_IDLE_HALT];
    assign gate_accumulate  = control_ff[BIT_GATE];
    assign prescale_select  = control_ff[BIT_PRE_HI:BIT_PRE_LO];
    assign clock_source_sel = control_ff[BIT_CLK_SRC];

    // two-flop synchroniser plus an edge stage for the pin
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            ext_s1_ff <= 1'b0;
            ext_s2_ff <= 1'b0;
            ext_s3_ff <= 1'b0;
        end else begin
            ext_s1_ff <= ext_clock_pin;
            ext_s2_ff <= ext_s1_ff;
            ext_s3_ff <= ext_s2_ff;
        end
    end

    // bus decode: a request is answered on the edge where waitrequest is low
    always_comb begin
        access_done = (avs_read || avs_write) && !wait_ff;
        wr_control  = 1'b0;
        wr_count    = 1'b0;
        wr_period   = 1'b0;
        if (avs_write && access_done && avs_address == OFS_CONTROL) begin
            wr_control = 1'b1;
        end else if (avs_write && access_done && avs_address == OFS_COUNT_HIGH) begin
            wr_count = 1'b1;
        end else if (avs_write && access_done && avs_address == OFS_PERIOD_HIGH) begin
            wr_period = 1'b1;
        end
    end

    // one wait cycle per access, read data loaded as waitrequest falls
    always_comb begin
        nxt_wait  = !((avs_read || avs_write) && wait_ff);
        nxt_rdata = rdata_ff;
        if (avs_read && wait_ff) begin
            if (avs_address == OFS_CONTROL) begin
                nxt_rdata = {16'h0000, control_ff};
            end else if (avs_address == OFS_COUNT_HIGH) begin
                nxt_rdata = {16'h0000, count_ff};
            end else if (avs_address == OFS_PERIOD_HIGH) begin
                nxt_rdata = {16'h0000, period_ff};
            end else begin
                nxt_rdata = 32'h00000000;     // unmapped reads as zero
            end
        end
    end

    // tick sources, prescaler and period compares
    always_comb begin
        halted     = idle_halt && cpu_idle;                                  // R2
        single_run = timer_run && !pair_wide_select && !halted;              // R1 R5
        gate_fall  = ext_s3_ff && !ext_s2_ff;
        if (clock_source_sel) begin
            raw_tick = ext_s2_ff && !ext_s3_ff;                              // R6
        end else if (gate_accumulate) begin
            raw_tick = ext_s2_ff;                                            // R3
        end else begin
            raw_tick = 1'b1;                                                 // R6
        end
        case (prescale_select)                                               // R4
            PRE_8:   pre_last = PRE_LAST_8;
            PRE_64:  pre_last = PRE_LAST_64;
            PRE_256: pre_last = PRE_LAST_256;
            default: pre_last = PRE_LAST_1;
        endcase
        pre_tick     = single_run && raw_tick && (pre_cnt_ff >= pre_last);
        nxt_pre_cnt  = pre_cnt_ff;
        if (!single_run) begin
            nxt_pre_cnt = PRE_ZERO;
        end else if (raw_tick) begin
            nxt_pre_cnt = (pre_cnt_ff >= pre_last) ? PRE_ZERO : pre_cnt_ff + PRE_ONE;
        end
        period_match = (count_ff == period_ff);
        pair_step    = pair_wide_select && pair_run && pair_tick && !halted;  // R2 R5
        pair_match   = ({count_ff, count_low_word} == {period_ff, period_low_word}); // R8
    end

    // count, wrap and interrupt next values
    always_comb begin
        nxt_count   = count_ff;
        nxt_control = control_ff;
        nxt_period  = period_ff;
        nxt_wrap    = 1'b0;
        nxt_irq     = 1'b0;
        if (pair_step) begin
            if (pair_match) begin
                nxt_count = COUNT_RESET;                                     // R7
                nxt_wrap  = 1'b1;
                nxt_irq   = 1'b1;                                            // R9
            end else if (count_low_word == WORD_ALL_ONES) begin
                nxt_count = count_ff + WORD_ONE;                             // R7
            end
        end else if (pre_tick) begin
            if (period_match) begin
                nxt_count = COUNT_RESET;
                nxt_irq   = !(gate_accumulate && !clock_source_sel);
            end else begin
                nxt_count = count_ff + WORD_ONE;                             // R1
            end
        end
        if (single_run && gate_accumulate && !clock_source_sel && gate_fall) begin
            nxt_irq = 1'b1;                                                  // R3
        end
        if (wr_count) begin
            nxt_count = avs_writedata[15:0];
        end
        if (wr_control) begin
            nxt_control = avs_writedata[15:0] & CONTROL_WMASK;
        end
        if (wr_period) begin
            nxt_period = avs_writedata[15:0];
        end
    end

    // state registers
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            control_ff <= CONTROL_RESET;
            count_ff   <= COUNT_RESET;
            period_ff  <= PERIOD_RESET;
            pre_cnt_ff <= PRE_ZERO;
            rdata_ff   <= 32'h00000000;
            wait_ff    <= 1'b1;
            wrap_ff    <= 1'b0;
            irq_ff     <= 1'b0;
        end else begin
            control_ff <= nxt_control;
            count_ff   <= nxt_count;
            period_ff  <= nxt_period;
            pre_cnt_ff <= nxt_pre_cnt;
            rdata_ff   <= nxt_rdata;
            wait_ff    <= nxt_wait;
            wrap_ff    <= nxt_wrap;
            irq_ff     <= nxt_irq;
        end
    end

    assign avs_readdata    = rdata_ff;
    assign avs_waitrequest = wait_ff;
    assign pair_wrap       = wrap_ff;
    assign timer_irq       = irq_ff;
    assign count_high_word = count_ff;

    // checks on the control behaviour
    sequence s_no_count_write;
        !(avs_write && !avs_waitrequest && avs_address == OFS_COUNT_HIGH);
    endsequence

    sequence s_pair_carry;
        pair_wide_select && pair_run && pair_tick && !(idle_halt && cpu_idle)
            && count_low_word == WORD_ALL_ONES && !pair_match;
    endsequence

    property p_stop_holds;
        @(posedge clock) disable iff (!reset_n)
        (!timer_run && !pair_wide_select && !wr_count)
            |=> count_high_word == $past(count_high_word);
    endproperty
    a_stop_holds: assert property (p_stop_holds) else $error("count moved while stopped"); // R1

    property p_run_1to1;
        @(posedge clock) disable iff (!reset_n)
        (single_run && !clock_source_sel && !gate_accumulate && prescale_select == PRE_1
            && !period_match && !wr_count && !wr_control)
            |=> count_high_word == $past(count_high_word) + WORD_ONE;
    endproperty
    a_run_1to1: assert property (p_run_1to1) else $error("count did not step at 1:1"); // R1

    property p_idle_halt;
        @(posedge clock) disable iff (!reset_n)
        (idle_halt && cpu_idle && !wr_count)
            |=> count_high_word == $past(count_high_word);
    endproperty
    a_idle_halt: assert property (p_idle_halt) else $error("count moved in idle halt"); // R2

    property p_gate_low;
        @(posedge clock) disable iff (!reset_n)
        (!pair_wide_select && gate_accumulate && !clock_source_sel && !ext_s2_ff)
            |-> !pre_tick;
    endproperty
    a_gate_low: assert property (p_gate_low) else $error("tick with gate low"); // R3

    property p_prescale_8;
        @(posedge clock) disable iff (!reset_n)
        // a count left from a wider ratio is folded back at the next raw tick, one edge later only on the internal clock with no gate or the gate high
        prescale_select == PRE_8 |=> pre_cnt_ff <= PRE_LAST_8;
    endproperty
    a_prescale_8: assert property (p_prescale_8) else $error("1:8 divider overran"); // R4

    property p_pair_carry;
        @(posedge clock) disable iff (!reset_n)
        (s_pair_carry and s_no_count_write)
            |=> count_high_word == $past(count_high_word) + WORD_ONE;
    endproperty
    a_pair_carry: assert property (p_pair_carry) else $error("high word missed carry"); // R7

    property p_pair_ignores;
        @(posedge clock) disable iff (!reset_n)
        pair_wide_select |-> !pre_tick;
    endproperty
    a_pair_ignores: assert property (p_pair_ignores) else $error("own tick in pair mode"); // R5

    property p_pair_wrap;
        @(posedge clock) disable iff (!reset_n)
        (pair_step && pair_match && !wr_count)
            |=> pair_wrap && timer_irq && count_high_word == COUNT_RESET ##1 !pair_wrap;
    endproperty
    a_pair_wrap: assert property (p_pair_wrap) else $error("pair period wrap wrong"); // R8

    property p_wrap_irq;
        @(posedge clock) disable iff (!reset_n)
        pair_wrap |-> timer_irq;
    endproperty
    a_wrap_irq: assert property (p_wrap_irq) else $error("pair wrap without irq"); // R9
endmodule

/* src/utc_pkg.sv */
// package for the upper timer control block: offsets, field positions, constants
// assumes a 32-bit avalon-mm slave with byte addresses and one clock at 200 MHz
package utc_pkg;
    localparam int          ADDR_W          = 4;
    localparam int          DATA_W          = 32;
    localparam int          WORD_W          = 16;
    // register byte offsets
    localparam logic [3:0]  OFS_CONTROL     = 4'h0;
    localparam logic [3:0]  OFS_COUNT_HIGH  = 4'h4;
    localparam logic [3:0]  OFS_PERIOD_HIGH = 4'h8;
    // control field positions
    localparam int          BIT_RUN         = 15;
    localparam int          BIT_IDLE_HALT   = 13;
    localparam int          BIT_GATE        = 6;
    localparam int          BIT_PRE_HI      = 5;
    localparam int          BIT_PRE_LO      = 4;
    localparam int          BIT_CLK_SRC     = 1;
    localparam logic [15:0] CONTROL_WMASK   = 16'hA072;
    localparam logic [15:0] CONTROL_RESET   = 16'h0000;
    localparam logic [15:0] COUNT_RESET     = 16'h0000;
    localparam logic [15:0] PERIOD_RESET    = 16'hFFFF;
    localparam logic [15:0] WORD_ALL_ONES   = 16'hFFFF;
    localparam logic [15:0] WORD_ONE        = 16'h0001;
    // prescale codes and terminal counts of the divider
    localparam logic [1:0]  PRE_1           = 2'h0;
    localparam logic [1:0]  PRE_8           = 2'h1;
    localparam logic [1:0]  PRE_64          = 2'h2;
    localparam logic [1:0]  PRE_256         = 2'h3;
    localparam logic [7:0]  PRE_LAST_1      = 8'h00;
    localparam logic [7:0]  PRE_LAST_8      = 8'h07;
    localparam logic [7:0]  PRE_LAST_64     = 8'h3F;
    localparam logic [7:0]  PRE_LAST_256    = 8'hFF;
    localparam logic [7:0]  PRE_ONE         = 8'h01;
    localparam logic [7:0]  PRE_ZERO        = 8'h00;
endpackage

/* verif/tb_upper_timer_control.sv */
// self-checking bench for the upper timer control block
// assumes utc_pkg and utc_upper_timer compiled first; bench drives every port itself
`timescale 1ns/1ps
module tb_upper_timer_control;
    import utc_pkg::*;
    typedef struct packed {
        logic        wr;
        logic [3:0]  addr;
        logic [31:0] wdata;
        logic [31:0] exp;
    } utc_row_type;
    logic        clock, reset_n, avs_read, avs_write, avs_waitrequest;
    logic [3:0]  avs_address;
    logic [31:0] avs_writedata, avs_readdata, rd, a;
    logic        cpu_idle, ext_clock_pin, pair_wide_select, pair_run, pair_tick;
    logic        pair_wrap, timer_irq;
    logic [15:0] count_low_word, period_low_word, count_high_word;
    int          mismatches, checked, gap;
    int          div [4] = '{1, 8, 64, 256};
    utc_row_type rows [10] = '{
        '{1'b0, 4'h0, 32'h0, 32'h0},        '{1'b0, 4'h4, 32'h0, 32'h0},
        '{1'b0, 4'h8, 32'h0, 32'hFFFF},     '{1'b1, 4'h0, 32'hFFFF, 32'h0},
        '{1'b0, 4'h0, 32'h0, 32'hA072},     '{1'b1, 4'h0, 32'h0, 32'h0},
        '{1'b1, 4'h8, 32'hABCD1234, 32'h0}, '{1'b0, 4'h8, 32'h0, 32'h1234},
        '{1'b1, 4'hC, 32'h5555, 32'h0},     '{1'b0, 4'hC, 32'h0, 32'h0}};

    utc_upper_timer DUT (.clock(clock), .reset_n(reset_n), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .cpu_idle(cpu_idle),
        .ext_clock_pin(ext_clock_pin), .pair_wide_select(pair_wide_select),
        .pair_run(pair_run), .pair_tick(pair_tick), .count_low_word(count_low_word),
        .period_low_word(period_low_word), .pair_wrap(pair_wrap), .timer_irq(timer_irq),
        .count_high_word(count_high_word));

    // 200 MHz clock
    initial begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end

    // compare and count
    task check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("Error at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask

    // one avalon access, held until waitrequest sampled low
    task bus(input logic wr, input logic [3:0] ad, input logic [31:0] wd);
        int n;
        n = 0;
        avs_address <= ad;
        avs_write <= wr;
        avs_read <= ~wr;
        avs_writedata <= wd;
        do begin
            @(posedge clock);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 50);
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge clock);
        if (n >= 50) check(32'h0, 32'h1, "bus timeout");
    endtask

    // edges from one irq pulse to the next
    task irq_gap(output int g);
        int n;
        n = 0;
        while (timer_irq !== 1'b1 && n < 2000) begin
            @(posedge clock);
            n++;
        end
        @(posedge clock);
        g = 1;
        while (timer_irq !== 1'b1 && g < 2000) begin
            @(posedge clock);
            g++;
        end
    endtask

    task wait_clk(input int n);
        repeat (n) @(posedge clock);
    endtask

    // one pair tick pulse, then look at the edge where outputs land
    task tick_pair();
        pair_tick <= 1'b1;
        @(posedge clock);
        pair_tick <= 1'b0;
        @(posedge clock);
    endtask

    task stop_test();
        $display("comparisons %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask

    // watchdog well beyond the expected run
    initial begin
        repeat (40000) @(posedge clock);
        mismatches++;
        stop_test();
    end

    // main sequence
    initial begin
        {avs_read, avs_write, cpu_idle, ext_clock_pin} = '0;
        {pair_wide_select, pair_run, pair_tick} = '0;
        {avs_address, avs_writedata, count_low_word, period_low_word} = '0;
        mismatches = 0;
        checked = 0;
        reset_n = 1'b0;
        wait_clk(8);
        reset_n <= 1'b1;
        check(32'(avs_waitrequest), 32'h1, "wait in reset");
        foreach (rows[i]) begin
            bus(rows[i].wr, rows[i].addr, rows[i].wdata);
            if (!rows[i].wr) check(rd, rows[i].exp, "register row");
        end
        $display("register rows done");
        // prescale ratios measured as irq spacing with period 1
        bus(1'b1, OFS_PERIOD_HIGH, 32'h1);
        for (int c = 0; c < 4; c++) begin
            bus(1'b1, OFS_COUNT_HIGH, 32'h0);
            bus(1'b1, OFS_CONTROL, 32'h8000 | (c << 4));
            irq_gap(gap);
            check(32'(gap), 32'(2 * div[c]), "prescale gap");
            bus(1'b1, OFS_CONTROL, 32'h0);
        end
        $display("prescale done");
        // run then stop keeps the count
        bus(1'b1, OFS_PERIOD_HIGH, 32'hFFFF);
        bus(1'b1, OFS_COUNT_HIGH, 32'h0);
        bus(1'b1, OFS_CONTROL, 32'h8000);
        wait_clk(10);
        bus(1'b1, OFS_CONTROL, 32'h0);
        a = 32'(count_high_word);
        check(32'(a != 0), 32'h1, "counted");
        wait_clk(20);
        check(32'(count_high_word), a, "held when stopped");
        // idle halt set then clear
        cpu_idle <= 1'b1;
        bus(1'b1, OFS_CONTROL, 32'hA000);
        a = 32'(count_high_word);
        wait_clk(20);
        check(32'(count_high_word), a, "halted in idle");
        bus(1'b1, OFS_CONTROL, 32'h8000);
        wait_clk(20);
        check(32'(count_high_word != a[15:0]), 32'h1, "runs in idle");
        cpu_idle <= 1'b0;
        $display("run and idle done");
        // external clock with gate bit set: gate ignored, counts pin edges
        bus(1'b1, OFS_CONTROL, 32'h0);
        bus(1'b1, OFS_COUNT_HIGH, 32'h0);
        bus(1'b1, OFS_CONTROL, 32'h8042);
        repeat (5) begin
            ext_clock_pin <= 1'b1;
            wait_clk(4);
            ext_clock_pin <= 1'b0;
            wait_clk(4);
        end
        check(32'(count_high_word), 32'h5, "external edges");
        // gated accumulation on internal clock
        bus(1'b1, OFS_CONTROL, 32'h0);
        bus(1'b1, OFS_COUNT_HIGH, 32'h0);
        bus(1'b1, OFS_CONTROL, 32'h8040);
        wait_clk(20);
        check(32'(count_high_word), 32'h0, "gate closed");
        ext_clock_pin <= 1'b1;
        wait_clk(10);
        ext_clock_pin <= 1'b0;
        gap = 0;
        while (timer_irq !== 1'b1 && gap < 6) begin
            @(posedge clock);
            gap++;
        end
        check(32'(timer_irq), 32'h1, "gate fall irq");
        check(32'(count_high_word >= 8 && count_high_word <= 12), 32'h1, "gated");
        bus(1'b1, OFS_CONTROL, 32'h0);
        $display("clock source and gate done");
        // pair mode: own controls off yet the pair counts
        pair_wide_select <= 1'b1;
        pair_run <= 1'b1;
        period_low_word <= 16'h0010;
        count_low_word <= 16'hFFFF;
        bus(1'b1, OFS_PERIOD_HIGH, 32'h2);
        bus(1'b1, OFS_COUNT_HIGH, 32'h0);
        tick_pair();
        @(posedge clock);
        check(32'(count_high_word), 32'h1, "pair carry");
        count_low_word <= 16'h0010;
        bus(1'b1, OFS_COUNT_HIGH, 32'h2);
        tick_pair();
        check(32'(pair_wrap), 32'h1, "pair wrap");
        check(32'(timer_irq), 32'h1, "pair irq");
        check(32'(count_high_word), 32'h0, "pair cleared");
        // own run at 1:1 must not step the high word in pair mode
        bus(1'b1, OFS_CONTROL, 32'h8000);
        wait_clk(10);
        check(32'(count_high_word), 32'h0, "own run ignored");
        // pair mode halted in idle by idle halt
        count_low_word <= 16'hFFFF;
        cpu_idle <= 1'b1;
        bus(1'b1, OFS_CONTROL, 32'h2000);
        tick_pair();
        @(posedge clock);
        check(32'(count_high_word), 32'h0, "pair idle halt");
        $display("pair mode done");
        // reset in mid-run clears count and control
        pair_wide_select <= 1'b0;
        cpu_idle <= 1'b0;
        bus(1'b1, OFS_CONTROL, 32'h8000);
        wait_clk(5);
        reset_n <= 1'b0;
        wait_clk(2);
        check(32'(count_high_word), 32'h0, "count in reset");
        check(32'(avs_waitrequest), 32'h1, "wait in mid reset");
        reset_n <= 1'b1;
        bus(1'b0, OFS_CONTROL, 32'h0);
        check(rd, 32'h0, "control after reset");
        wait_clk(5);
        check(32'(count_high_word), 32'h0, "stopped after reset");
        $display("mid-run reset done");
        stop_test();
    end
endmodule
